// ==== design/ztf_frame_byte.sv ====
// frame byte generator: gives the byte at a frame position.
// assumes a latched request, and the running sum of bytes 3 onward.
`timescale 1ns/1ps
`include "ztf_cfg.svh"

module ztf_frame_byte (
   input ztf_pkg::ztf_req_t req,
   input wire logic [5:0] idx,
   input wire logic [7:0] sum,
   output logic [7:0] byte_o,
   output logic [5:0] last_o
);

   logic uni; // unicast frame
   logic [5:0] plen; // payload length
   logic [15:0] clus; // cluster id
   logic [63:0] d64; // 64-bit destination
   logic [15:0] d16; // 16-bit destination
   logic [7:0] rtype; // request type byte
   logic [15:0] len; // length field
   logic [5:0] p; // payload position

   // ----------------------------------------------------------------
   // byte selection
   // ----------------------------------------------------------------
   always_comb begin
      // neighbour table queries always go unicast [R13]
      uni = !req.bcast || req.kind == ztf_pkg::ZTF_LQI;
      case (req.kind)
         ztf_pkg::ZTF_NWK: begin
            plen = `ZTF_PLEN_NWK;
            clus = `ZTF_CL_NWK; // [R7]
         end
         ztf_pkg::ZTF_IEEE: begin
            plen = `ZTF_PLEN_IEEE;
            clus = `ZTF_CL_IEEE; // [R7]
         end
         ztf_pkg::ZTF_NODE: begin
            plen = `ZTF_PLEN_NODE;
            clus = `ZTF_CL_NODE; // [R7]
         end
         default: begin
            plen = `ZTF_PLEN_LQI; // [R13]
            clus = `ZTF_CL_LQI; // [R7]
         end
      endcase
      d64 = uni ? req.addr : `ZTF_BCAST64; // [R5]
      // unknown short address or broadcast [R6]
      d16 = (uni && req.known) ? req.nwk : `ZTF_D16_UNKNOWN;
      rtype = req.ext ? `ZTF_REQ_EXT : `ZTF_REQ_SINGLE; // [R11]
      // bytes after length, checksum excluded [R2]
      len = {10'h000, `ZTF_HDR_LEN + plen};
      last_o = `ZTF_IDX_PAY + plen;
      p = idx - `ZTF_IDX_PAY;
      byte_o = 8'h00;
      // header, most significant byte first [R1] [R14]
      if (idx == 6'd0) begin
         byte_o = `ZTF_DELIM;
      end else if (idx == 6'd1) begin
         byte_o = len[15:8];
      end else if (idx == 6'd2) begin
         byte_o = len[7:0];
      end else if (idx == `ZTF_IDX_TYPE) begin
         byte_o = `ZTF_FRAME_TYPE;
      end else if (idx == 6'd4) begin
         byte_o = req.tag; // zero asks for no status reply [R4]
      end else if (idx <= `ZTF_IDX_D64_END) begin
         byte_o = 8'(d64 >> {`ZTF_IDX_D64_END - idx, 3'b000});
      end else if (idx == 6'd13) begin
         byte_o = d16[15:8];
      end else if (idx == 6'd14) begin
         byte_o = d16[7:0];
      end else if (idx == 6'd15 || idx == 6'd16) begin
         byte_o = `ZTF_ENDPOINT; // [R8]
      end else if (idx == 6'd17) begin
         byte_o = clus[15:8];
      end else if (idx == 6'd18) begin
         byte_o = clus[7:0];
      end else if (idx == 6'd19) begin
         byte_o = 8'(`ZTF_PROFILE >> 8); // [R8]
      end else if (idx == 6'd20) begin
         byte_o = 8'(`ZTF_PROFILE);
      end else if (idx == 6'd21) begin
         byte_o = `ZTF_RADIUS; // [R15]
      end else if (idx == 6'd22) begin
         byte_o = `ZTF_TX_OPTS; // [R15]
      end else if (idx == last_o) begin
         byte_o = `ZTF_CKS_BASE - sum; // [R3]
      end else if (p == 6'd0) begin
         byte_o = req.seq; // [R9]
      end else if (req.kind == ztf_pkg::ZTF_NWK) begin
         // little-endian target address [R10]
         if (p <= 6'd8) begin
            byte_o = 8'(req.addr >> {p - 6'd1, 3'b000});
         end else if (p == 6'd9) begin
            byte_o = rtype;
         end else begin
            byte_o = req.sidx;
         end
      end else if (req.kind == ztf_pkg::ZTF_LQI) begin
         byte_o = req.sidx; // [R13]
      end else begin
         // little-endian short address [R12]
         if (p == 6'd1) begin
            byte_o = req.nwk[7:0];
         end else if (p == 6'd2) begin
            byte_o = req.nwk[15:8];
         end else if (p == 6'd3) begin
            byte_o = rtype;
         end else begin
            byte_o = req.sidx;
         end
      end
   end

endmodule

// ==== design/ztf_framer.sv ====
// transmit-request framer: builds device-object request frames
// for the radio module's serial link from wishbone registers.
// assumes one clock, a byte sink with valid/ready, classic wishbone.
//
// Function
// R1: delimiter, length, type, header, payload, checksum order
// R2: length counts bytes after it, minus checksum
// R3: checksum is ff minus sum after length
// R4: reply tag zero suppresses status reply
// R5: broadcast uses 64-bit destination 0000ffff
// R6: 16-bit destination fffe on broadcast or unknown
// R7: cluster 0000, 0001, 0002, 0031 by request
// R8: profile and both endpoints are zero
// R9: payload opens with transaction sequence byte
// R10: address request: LE address, type, index
// R11: request type 01 selects extended answer
// R12: ieee, descriptor requests: LE short address
// R13: neighbour query unicast, sequence plus index
// R14: header fields go most significant first
// R15: radius and options bytes are zero
`timescale 1ns/1ps
`include "ztf_cfg.svh"

module ztf_framer #(
   parameter int ADR_W = 8 // wishbone byte address width
) (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic [ADR_W-1:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic WB_WE_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic [7:0] TX_DATA,
   output logic TX_VALID,
   output logic TX_LAST,
   input wire logic TX_READY,
   output logic BUSY
);

   // ----------------------------------------------------------------
   // state and helpers
   // ----------------------------------------------------------------
   ztf_pkg::ztf_state_t s; // registered state
   ztf_pkg::ztf_state_t next_s; // next state
   logic hit; // bus request present
   logic wr; // write takes effect now
   logic start; // start bit written
   logic clr_done; // done clear written
   logic [5:0] idx_n; // position of the byte to load
   logic [7:0] nb; // byte at idx_n
   logic [5:0] last; // checksum position
   logic [7:0] ofs; // register offset
   logic [31:0] rd; // read mux

   // byte lane merge for writes
   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] wdat,
      input logic [3:0] sel
   );
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = wdat[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // frame byte generator
   // ----------------------------------------------------------------
   assign idx_n = s.idx + 6'd1;

   ztf_frame_byte u_byte (
      .req(s.req),
      .idx(idx_n),
      .sum(s.sum),
      .byte_o(nb),
      .last_o(last)
   );

   // ----------------------------------------------------------------
   // register read mux
   // ----------------------------------------------------------------
   assign ofs = 8'(WB_ADR_I);

   always_comb begin
      rd = 32'h0000_0000;
      case (ofs)
         `ZTF_OFF_CTRL: begin
            // start reads as zero
            rd[`ZTF_CTRL_KIND +: 2] = s.cfg.kind;
            rd[`ZTF_CTRL_BCAST] = s.cfg.bcast;
            rd[`ZTF_CTRL_KNOWN] = s.cfg.known;
            rd[`ZTF_CTRL_EXT] = s.cfg.ext;
         end
         `ZTF_OFF_TAG: begin
            rd[23:0] = {s.cfg.sidx, s.cfg.seq, s.cfg.tag};
         end
         `ZTF_OFF_ADDR_LO: begin
            rd = s.cfg.addr[31:0];
         end
         `ZTF_OFF_ADDR_HI: begin
            rd = s.cfg.addr[63:32];
         end
         `ZTF_OFF_NWK: begin
            rd[15:0] = s.cfg.nwk;
         end
         `ZTF_OFF_STATUS: begin
            // framer's own state
            rd[`ZTF_STAT_BUSY] = s.busy;
            rd[`ZTF_STAT_DONE] = s.done;
            rd[`ZTF_STAT_CKS +: 8] = s.cks;
         end
         default: begin
            // unmapped: acknowledged, reads zero
            rd = 32'h0000_0000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      hit = WB_CYC_I && WB_STB_I;
      // ack one cycle after the request, dropped the cycle after
      next_s.ack = hit && !s.ack;
      if (hit && !s.ack) begin
         next_s.dat = rd;
      end
      // writes land on the edge where ack is seen high
      wr = hit && s.ack && WB_WE_I;
      start = 1'b0;
      clr_done = 1'b0;
      if (wr) begin
         case (ofs)
            `ZTF_OFF_CTRL: begin
               if (WB_SEL_I[0]) begin
                  next_s.cfg.kind = ztf_pkg::ztf_kind_t'(
                     WB_DAT_I[`ZTF_CTRL_KIND +: 2]);
                  next_s.cfg.bcast = WB_DAT_I[`ZTF_CTRL_BCAST];
                  next_s.cfg.known = WB_DAT_I[`ZTF_CTRL_KNOWN];
                  next_s.cfg.ext = WB_DAT_I[`ZTF_CTRL_EXT];
                  start = WB_DAT_I[`ZTF_CTRL_START];
               end
            end
            `ZTF_OFF_TAG: begin
               {next_s.cfg.sidx, next_s.cfg.seq, next_s.cfg.tag} =
                  24'(merge({8'h00, s.cfg.sidx, s.cfg.seq, s.cfg.tag},
                  WB_DAT_I, WB_SEL_I));
            end
            `ZTF_OFF_ADDR_LO: begin
               next_s.cfg.addr[31:0] =
                  merge(s.cfg.addr[31:0], WB_DAT_I, WB_SEL_I);
            end
            `ZTF_OFF_ADDR_HI: begin
               next_s.cfg.addr[63:32] =
                  merge(s.cfg.addr[63:32], WB_DAT_I, WB_SEL_I);
            end
            `ZTF_OFF_NWK: begin
               next_s.cfg.nwk = 16'(merge({16'h0000, s.cfg.nwk},
                  WB_DAT_I, WB_SEL_I));
            end
            `ZTF_OFF_STATUS: begin
               // write one to clear done
               clr_done = WB_SEL_I[0] && WB_DAT_I[`ZTF_STAT_DONE];
            end
            default: begin
               // unmapped write is dropped
               clr_done = 1'b0;
            end
         endcase
      end
      if (clr_done) begin
         next_s.done = 1'b0;
      end
      case (s.fsm)
         ztf_pkg::ZTF_IDLE: begin
            // a start is taken only while idle
            if (start) begin
               next_s.fsm = ztf_pkg::ZTF_SEND;
               next_s.req = next_s.cfg;
               next_s.idx = 6'd0;
               next_s.sum = 8'h00;
               next_s.tx_data = `ZTF_DELIM; // [R1]
               next_s.tx_valid = 1'b1;
               next_s.tx_last = 1'b0;
            end
         end
         ztf_pkg::ZTF_SEND: begin
            // advance only on a taken byte
            if (s.tx_valid && TX_READY) begin
               if (s.tx_last) begin
                  next_s.fsm = ztf_pkg::ZTF_IDLE;
                  next_s.tx_valid = 1'b0;
                  next_s.tx_last = 1'b0;
                  next_s.cks = s.tx_data;
                  next_s.done = 1'b1; // set wins over clear
               end else begin
                  next_s.idx = idx_n;
                  next_s.tx_data = nb; // [R1]
                  next_s.tx_last = idx_n == last;
                  // sum bytes after length, not checksum [R3]
                  if (idx_n >= `ZTF_IDX_TYPE && idx_n < last) begin
                     next_s.sum = s.sum + nb;
                  end
               end
            end
         end
         default: begin
            next_s.fsm = ztf_pkg::ZTF_IDLE;
         end
      endcase
      next_s.busy = next_s.fsm == ztf_pkg::ZTF_SEND;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------
   assign WB_DAT_O = s.dat;
   assign WB_ACK_O = s.ack;
   assign TX_DATA = s.tx_data;
   assign TX_VALID = s.tx_valid;
   assign TX_LAST = s.tx_last;
   assign BUSY = s.busy;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);

   // idle framer sees a start write
   sequence start_seen;
      s.fsm == ztf_pkg::ZTF_IDLE && wr && ofs == `ZTF_OFF_CTRL
         && WB_SEL_I[0] && WB_DAT_I[`ZTF_CTRL_START];
   endsequence

   // final byte taken by the sink
   sequence last_taken;
      s.tx_valid && s.tx_last && TX_READY;
   endsequence

   // a byte offered at a position
   sequence at_pos(int pos);
      s.tx_valid && s.idx == 6'(pos);
   endsequence

   frame_open_a: assert property ( // [R1]
      start_seen |=> TX_VALID && TX_DATA == `ZTF_DELIM && BUSY
         ##0 at_pos(0))
      else $error("frame did not open with the delimiter");

   type_byte_a: assert property ( // [R1]
      at_pos(3) |-> TX_DATA == `ZTF_FRAME_TYPE)
      else $error("frame type byte wrong");

   length_lo_a: assert property ( // [R2]
      at_pos(2) |-> TX_DATA == {2'b00, `ZTF_HDR_LEN
         + (s.req.kind == ztf_pkg::ZTF_NWK ? `ZTF_PLEN_NWK
         : s.req.kind == ztf_pkg::ZTF_IEEE ? `ZTF_PLEN_IEEE
         : s.req.kind == ztf_pkg::ZTF_NODE ? `ZTF_PLEN_NODE
         : `ZTF_PLEN_LQI)})
      else $error("length byte wrong");

   cks_byte_a: assert property ( // [R3]
      s.tx_valid && s.tx_last |-> s.idx == last
         && TX_DATA == 8'(`ZTF_CKS_BASE - s.sum))
      else $error("checksum byte wrong");

   reply_tag_a: assert property ( // [R4]
      at_pos(4) |-> TX_DATA == s.req.tag)
      else $error("reply tag byte wrong");

   short_dest_a: assert property ( // [R6]
      at_pos(14) && s.req.bcast && s.req.kind != ztf_pkg::ZTF_LQI
         |-> TX_DATA == 8'hfe)
      else $error("broadcast short destination wrong");

   zero_fields_a: assert property ( // [R8] [R15]
      s.tx_valid && (s.idx == 6'd15 || s.idx == 6'd16
         || (s.idx >= 6'd19 && s.idx <= 6'd22)) |-> TX_DATA == 8'h00)
      else $error("endpoint, profile, radius or options not zero");

   seq_first_a: assert property ( // [R9]
      at_pos(23) |-> TX_DATA == s.req.seq)
      else $error("payload does not open with sequence byte");

   byte_hold_a: assert property (
      s.tx_valid && !TX_READY |=> $stable(TX_DATA) && TX_VALID
         && $stable(s.idx))
      else $error("offered byte changed while stalled");

   frame_close_a: assert property ( // [R3]
      last_taken |=> !TX_VALID && !BUSY && s.done
         && s.cks == $past(TX_DATA))
      else $error("frame did not close after checksum");

endmodule

// ==== shared/ztf_cfg.svh ====
// constants of the transmit-request framer: register map, field
// positions, fixed frame bytes and byte positions inside a frame.
// assumes byte addresses on a 32-bit classic wishbone register bus.
`ifndef ZTF_CFG_SVH
`define ZTF_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define ZTF_OFF_CTRL 8'h00
`define ZTF_OFF_TAG 8'h04
`define ZTF_OFF_ADDR_LO 8'h08
`define ZTF_OFF_ADDR_HI 8'h0c
`define ZTF_OFF_NWK 8'h10
`define ZTF_OFF_STATUS 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ZTF_CTRL_START 0
`define ZTF_CTRL_KIND 2
`define ZTF_CTRL_BCAST 4
`define ZTF_CTRL_KNOWN 5
`define ZTF_CTRL_EXT 6
`define ZTF_STAT_BUSY 0
`define ZTF_STAT_DONE 1
`define ZTF_STAT_CKS 8

// ----------------------------------------------------------------
// fixed frame contents
// ----------------------------------------------------------------
`define ZTF_DELIM 8'h7e
`define ZTF_FRAME_TYPE 8'h11
`define ZTF_D16_UNKNOWN 16'hfffe
`define ZTF_BCAST64 64'h0000_0000_0000_ffff
`define ZTF_CL_NWK 16'h0000
`define ZTF_CL_IEEE 16'h0001
`define ZTF_CL_NODE 16'h0002
`define ZTF_CL_LQI 16'h0031
`define ZTF_PROFILE 16'h0000
`define ZTF_ENDPOINT 8'h00
`define ZTF_RADIUS 8'h00
`define ZTF_TX_OPTS 8'h00
`define ZTF_REQ_EXT 8'h01
`define ZTF_REQ_SINGLE 8'h00
`define ZTF_CKS_BASE 8'hff

// ----------------------------------------------------------------
// byte positions and lengths
// ----------------------------------------------------------------
`define ZTF_HDR_LEN 6'd20
`define ZTF_IDX_TYPE 6'd3
`define ZTF_IDX_D64_END 6'd12
`define ZTF_IDX_PAY 6'd23
`define ZTF_PLEN_NWK 6'd11
`define ZTF_PLEN_IEEE 6'd5
`define ZTF_PLEN_NODE 6'd3
`define ZTF_PLEN_LQI 6'd2

`endif

// ==== shared/ztf_pkg.sv ====
// types of the transmit-request framer.
// assumes ztf_cfg.svh for every number.
package ztf_pkg;

   // request kinds, as coded in the control register
   typedef enum logic [1:0] {
      ZTF_NWK, ZTF_IEEE, ZTF_NODE, ZTF_LQI
   } ztf_kind_t;

   // framer sequencer
   typedef enum logic {ZTF_IDLE, ZTF_SEND} ztf_fsm_t;

   // one request as set up by software
   typedef struct packed {
      ztf_kind_t kind;
      logic bcast;
      logic known;
      logic ext;
      logic [7:0] tag;
      logic [7:0] seq;
      logic [7:0] sidx;
      logic [63:0] addr;
      logic [15:0] nwk;
   } ztf_req_t;

   // whole state of the top module
   typedef struct packed {
      ztf_fsm_t fsm;
      logic busy;
      logic [5:0] idx;
      logic [7:0] sum;
      ztf_req_t req;
      ztf_req_t cfg;
      logic ack;
      logic [31:0] dat;
      logic done;
      logic [7:0] cks;
      logic [7:0] tx_data;
      logic tx_valid;
      logic tx_last;
   } ztf_state_t;

endpackage

// ==== sim/testbench.sv ====
// self-checking bench of the transmit-request framer.
// assumes the framer on a wishbone master and a serial input model.
`timescale 1ns/1ps
`include "ztf_cfg.svh"

module testbench;
   logic CLK_SYS = 1'b0;
   logic SYS_RST = 1'b1;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dati = 32'h0;
   logic wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0;
   logic [3:0] wb_sel = 4'h0, bus_sel = 4'hf; // lanes driven, lanes wanted
   logic [31:0] wb_dato, rd;
   logic wb_ack, tx_valid, tx_last, tx_ready, busy, cks_ok, reply_due;
   logic [7:0] tx_data;
   logic slow = 1'b0; // sink pace
   int frames, got_n, f0;
   int fail_count = 0, compares = 0;
   logic [7:0] exp [$]; // expected frame bytes

   always #25 CLK_SYS = ~CLK_SYS;

   // ----------------------------------------------------------------
   // instances
   // ----------------------------------------------------------------
   ztf_framer #(.ADR_W(8)) dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
      .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dati), .WB_SEL_I(wb_sel),
      .WB_WE_I(wb_we), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
      .WB_DAT_O(wb_dato), .WB_ACK_O(wb_ack), .TX_DATA(tx_data),
      .TX_VALID(tx_valid), .TX_LAST(tx_last), .TX_READY(tx_ready),
      .BUSY(busy));
   ztf_dev_model dev (.clk(CLK_SYS), .rst(SYS_RST), .slow(slow),
      .rx_data(tx_data), .rx_valid(tx_valid), .rx_last(tx_last),
      .rx_ready(tx_ready), .frames(frames), .got_n(got_n),
      .cks_ok(cks_ok), .reply_due(reply_due));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want,
                        input string what);
      compares++;
      if (seen !== want) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, what,
                  seen, want);
      end
   endtask

   // one classic cycle: held until ack is sampled high
   task automatic wb_cycle(input logic w, input logic [7:0] a,
                           input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge CLK_SYS);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dati <= d;
      wb_sel <= bus_sel;
      n = 0;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      q = wb_dato;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      wb_sel <= 4'h0;
      if (n >= 20) begin
         fail_count++;
         $display("wrong value at %0t: bus timeout", $time);
         print_verdict();
      end
   endtask

   // expected frame worked out from the field values
   task automatic build_exp(input logic [1:0] k, input logic bc,
      input logic kn, input logic ext, input logic [7:0] tag,
      input logic [7:0] seq, input logic [7:0] sidx,
      input logic [63:0] addr, input logic [15:0] nwk);
      logic [63:0] d64;
      logic [15:0] d16, cl;
      logic [7:0] plen, s;
      if (k == 2'd3) bc = 1'b0; // neighbour query is unicast
      d64 = bc ? 64'h0000_0000_0000_ffff : addr;
      d16 = (bc || !kn) ? 16'hfffe : nwk;
      cl = (k == 2'd0) ? 16'h0000 : (k == 2'd1) ? 16'h0001 :
           (k == 2'd2) ? 16'h0002 : 16'h0031;
      plen = (k == 2'd0) ? 8'd11 : (k == 2'd1) ? 8'd5 :
             (k == 2'd2) ? 8'd3 : 8'd2;
      exp.delete();
      exp = '{8'h7e, 8'h00, 8'd20 + plen, 8'h11, tag};
      for (int i = 7; i >= 0; i--) exp.push_back(d64[i*8+:8]);
      exp = {exp, d16[15:8], d16[7:0], 8'h00, 8'h00, cl[15:8], cl[7:0]};
      exp = {exp, 8'h00, 8'h00, 8'h00, 8'h00, seq};
      if (k == 2'd0)
         for (int i = 0; i < 8; i++) exp.push_back(addr[i*8+:8]);
      if (k == 2'd1 || k == 2'd2) exp = {exp, nwk[7:0], nwk[15:8]};
      if (k <= 2'd1) exp = {exp, ext ? 8'h01 : 8'h00, sidx};
      if (k == 2'd3) exp.push_back(sidx);
      s = 8'h00;
      for (int i = 3; i < exp.size(); i++) s = s + exp[i];
      exp.push_back(8'hff - s);
   endtask

   // load the request registers and start it
   task automatic prog_start(input logic [1:0] k, input logic bc,
      input logic kn, input logic ext, input logic [7:0] tag,
      input logic [7:0] seq, input logic [7:0] sidx,
      input logic [63:0] addr, input logic [15:0] nwk);
      build_exp(k, bc, kn, ext, tag, seq, sidx, addr, nwk);
      wb_cycle(1'b1, `ZTF_OFF_TAG, {8'h00, sidx, seq, tag}, rd);
      wb_cycle(1'b1, `ZTF_OFF_ADDR_LO, addr[31:0], rd);
      wb_cycle(1'b1, `ZTF_OFF_ADDR_HI, addr[63:32], rd);
      wb_cycle(1'b1, `ZTF_OFF_NWK, {16'h0000, nwk}, rd);
      f0 = frames;
      wb_cycle(1'b1, `ZTF_OFF_CTRL, {25'h0, ext, kn, bc, k, 2'b01}, rd);
      #1;
      check(busy, 1'b1, "busy after start");
   endtask

   // wait for the frame and compare it byte by byte
   task automatic finish_frame(input logic [7:0] tag);
      int n;
      n = 0;
      while (frames == f0 && n < 600) begin
         @(posedge CLK_SYS);
         n++;
      end
      if (n >= 600) begin
         fail_count++;
         $display("wrong value at %0t: frame timeout", $time);
         print_verdict();
      end
      check(got_n, exp.size(), "frame size");
      for (int i = 0; i < exp.size(); i++)
         check(dev.got[i], exp[i], "frame byte");
      check(cks_ok, 1'b1, "checksum");
      check(reply_due, tag != 8'h00, "status reply");
      @(posedge CLK_SYS);
      #1;
      check(busy, 1'b0, "busy after frame");
      wb_cycle(1'b0, `ZTF_OFF_STATUS, 32'h0, rd);
      check(rd, {16'h0, exp[exp.size()-1], 8'h02}, "status");
      wb_cycle(1'b1, `ZTF_OFF_STATUS, 32'h2, rd);
      wb_cycle(1'b0, `ZTF_OFF_STATUS, 32'h0, rd);
      check(rd, {16'h0, exp[exp.size()-1], 8'h00}, "done cleared");
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      wb_cycle(1'b0, `ZTF_OFF_CTRL, 32'h0, rd);
      check(rd, 32'h0, "ctrl reset");
      wb_cycle(1'b0, `ZTF_OFF_STATUS, 32'h0, rd);
      check(rd, 32'h0, "status reset");
      wb_cycle(1'b1, `ZTF_OFF_TAG, 32'h00a5c3e1, rd);
      wb_cycle(1'b0, `ZTF_OFF_TAG, 32'h0, rd);
      check(rd, 32'h00a5c3e1, "tag readback");
      // only the lane with its enable high may change
      bus_sel = 4'h2;
      wb_cycle(1'b1, `ZTF_OFF_TAG, 32'h55667788, rd);
      bus_sel = 4'hf;
      wb_cycle(1'b0, `ZTF_OFF_TAG, 32'h0, rd);
      check(rd, 32'h00a577e1, "byte lane write");
      wb_cycle(1'b1, 8'h20, 32'hffffffff, rd);
      wb_cycle(1'b0, 8'h20, 32'h0, rd);
      check(rd, 32'h0, "unmapped read");
   endtask

   // every kind as a broadcast, tag zero, fast and slow sink
   task automatic t_kinds();
      for (int k = 0; k < 4; k++) begin
         slow <= k[0];
         prog_start(k[1:0], 1'b1, 1'b0, !k[1], 8'h00, 8'h10 + k[7:0],
                    k[7:0], 64'h1122_3344_5566_7788, 16'h3344);
         finish_frame(8'h00);
      end
   endtask

   // unicast with known and unknown short address, nonzero tags
   task automatic t_unicast();
      slow <= 1'b0;
      prog_start(2'd0, 1'b0, 1'b1, 1'b1, 8'h5a, 8'h01, 8'h02,
                 64'h8877_6655_4433_2211, 16'h1234);
      finish_frame(8'h5a);
      prog_start(2'd1, 1'b0, 1'b0, 1'b0, 8'h01, 8'hfe, 8'h07,
                 64'h0102_0304_0506_0708, 16'habcd);
      finish_frame(8'h01);
      prog_start(2'd3, 1'b1, 1'b1, 1'b0, 8'hff, 8'h76, 8'h05,
                 64'hcafe_0000_1234_5678, 16'h0a0b);
      finish_frame(8'hff);
   endtask

   // a start written in mid-frame leaves the frame alone
   task automatic t_start_busy();
      slow <= 1'b1;
      prog_start(2'd2, 1'b0, 1'b1, 1'b0, 8'h33, 8'h03, 8'h00,
                 64'h0, 16'h4433);
      wb_cycle(1'b1, `ZTF_OFF_CTRL, 32'h0000000d, rd);
      finish_frame(8'h33);
      // fast sink, so a wrongly queued frame would finish in the wait
      slow <= 1'b0;
      repeat (60) @(posedge CLK_SYS);
      check(frames, f0 + 1, "no extra frame");
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      t_regs();
      t_kinds();
      t_unicast();
      t_start_busy();
      print_verdict();
   end
endmodule

// ==== sim/ztf_dev_model.sv ====
// radio module serial input model: takes framer bytes and checks frames.
// assumes one clock with the framer, bytes taken on valid and ready.
`timescale 1ns/1ps

module ztf_dev_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_last,
   output logic rx_ready,
   output int frames,
   output int got_n,
   output logic cks_ok,
   output logic reply_due
);
   logic [7:0] got [0:63]; // bytes of the last frame
   int n; // position inside the current frame
   logic [7:0] sum; // running sum from the type byte on
   logic [7:0] tag; // reply tag of the current frame
   logic [1:0] ph; // stall phase for the slow sink

   // ----------------------------------------------------------------
   // byte intake
   // ----------------------------------------------------------------
   // a slow sink takes one byte in four cycles, like a busy uart
   always @(posedge clk) begin
      if (rst) begin
         rx_ready <= 1'b0;
         frames <= 0;
         got_n <= 0;
         n <= 0;
         sum <= 8'h00;
         tag <= 8'h00;
         ph <= 2'h0;
         cks_ok <= 1'b0;
         reply_due <= 1'b0;
      end else begin
         ph <= ph + 2'h1;
         rx_ready <= slow ? (ph == 2'h3) : 1'b1;
         if (rx_valid && rx_ready) begin
            if (n < 64) got[n] <= rx_data;
            n <= n + 1;
            if (n >= 3) sum <= sum + rx_data;
            if (n == 4) tag <= rx_data;
            if (rx_last) begin
               cks_ok <= (sum + rx_data) == 8'hff;
               reply_due <= (tag != 8'h00);
               got_n <= n + 1;
               frames <= frames + 1;
               n <= 0;
               sum <= 8'h00;
            end
         end
      end
   end
endmodule
